// *** rtl/ecpp_pkg.sv ***
package ecpp_pkg;
  localparam int PORT_WORD_W = 8;
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_W = PORT_WORD_W + 1;
  localparam logic [10:0] OFF_DATA = 11'h000;
  localparam logic [10:0] OFF_STAT = 11'h001;
  localparam logic [10:0] OFF_CTRL = 11'h002;
  localparam logic [10:0] OFF_FIFO = 11'h400;
  localparam logic [10:0] OFF_CFGB = 11'h401;
  localparam logic [10:0] OFF_ECR = 11'h402;
  localparam logic [2:0] MODE_STD = 3'h0;
  localparam logic [2:0] MODE_BIDIR = 3'h1;
  localparam logic [2:0] MODE_COMPAT_DATA_FIFO = 3'h2;
  localparam logic [2:0] MODE_ECP = 3'h3;
  localparam logic [2:0] MODE_EPP = 3'h4;
  localparam logic [2:0] MODE_RSVD = 3'h5;
  localparam logic [2:0] MODE_TEST = 3'h6;
  localparam logic [2:0] MODE_CFG = 3'h7;
  localparam int CTRL_STROBE = 0;
  localparam int CTRL_AUTOFD = 1;
  localparam int CTRL_INIT = 2;
  localparam int CTRL_SELIN = 3;
  localparam int CTRL_ACKIE = 4;
  localparam int CTRL_DIR = 5;
  localparam int ECR_NERRIE = 4;
  localparam int ECR_DMA_ENABLE_BIT = 3;
  localparam int ECR_SVC = 2;
  localparam logic [5:0] CTRL_RST = 6'h00;
  localparam logic [2:0] MODE_RST = 3'h0;
  localparam logic [7:0] CONFIG_A_VAL = 8'h10;
  localparam logic [12:0] SYNC_RST = 13'h1700;
  localparam int CLK_NS = 8;
  localparam int STROBE_NS = 40;
  localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
  localparam int SVC_THRESH = 8;
  typedef enum logic [2:0] {
    LK_IDLE, LK_SETUP, LK_STROBE, LK_RELEASE, LK_REV_REQ, LK_REV_ACK
  } ecpp_link_e;
endpackage

// *** rtl/ecpp_sync.sv ***
`timescale 1ns/1ns
module ecpp_sync import ecpp_pkg::*; #(
  parameter int W = 13,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] stage_ff;
  logic [W-1:0] q_ff;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      stage_ff <= RST_VAL;
      q_ff <= RST_VAL;
    end else if (ce) begin
      stage_ff <= d;
      q_ff <= stage_ff;
    end
  end
  assign q = q_ff;
endmodule // ecpp_sync

// *** rtl/ecpp_fifo.sv ***
`timescale 1ns/1ns
module ecpp_fifo import ecpp_pkg::*; #(
  parameter int WIDTH = FIFO_W,
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic flush,
  input wire logic wrValid,
  output logic wrReady,
  input wire logic [WIDTH-1:0] wrData,
  output logic rdValid,
  input wire logic rdReady,
  output logic [WIDTH-1:0] rdData,
  output logic [$clog2(DEPTH):0] count
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr_ff, nxt_wrPtr, rdPtr_ff, nxt_rdPtr;
  logic [AW:0] count_ff, nxt_count;
  logic doWr, doRd;
  assign wrReady = count_ff != (AW+1)'(DEPTH);
  assign rdValid = count_ff != '0;
  assign rdData = mem[rdPtr_ff];
  assign count = count_ff;
  assign doWr = wrValid && wrReady;
  assign doRd = rdReady && rdValid;
  always_comb begin
    nxt_wrPtr = wrPtr_ff;
    nxt_rdPtr = rdPtr_ff;
    nxt_count = count_ff;
    if (flush) begin
      nxt_wrPtr = '0;
      nxt_rdPtr = '0;
      nxt_count = '0;
    end else begin
      if (doWr) nxt_wrPtr = AW'(wrPtr_ff + 1'b1);
      if (doRd) nxt_rdPtr = AW'(rdPtr_ff + 1'b1);
      nxt_count = (AW+1)'(count_ff + doWr - doRd);
    end
  end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wrPtr_ff <= '0;
      rdPtr_ff <= '0;
      count_ff <= '0;
    end else if (ce) begin
      wrPtr_ff <= nxt_wrPtr;
      rdPtr_ff <= nxt_rdPtr;
      count_ff <= nxt_count;
      if (doWr && !flush) mem[wrPtr_ff] <= wrData;
    end
  end
endmodule // ecpp_fifo

// *** rtl/ecpp_port.sv ***
`timescale 1ns/1ns
// Summary of operation
// RULE1 - every port word moved through the port is eight bits wide
// RULE2 - one shared sixteen entry fifo serves every fifo mode
// RULE3 - standard and bidirectional modes behave as a plain printer port
// RULE4 - no negotiation; automatic burst channel with dma in both directions
// RULE5 - fifo mode sends bytes with automatic strobe and busy handshake
// RULE6 - reverse run length count byte is dropped, next byte repeated count times; code stores that next byte count plus one times
// RULE7 - forward compression is optional and is not built here
// RULE8 - forward byte placed on data lines then strobe asserted, interlocked with busy
// RULE9 - peripheral drops busy when it can take the next forward byte
// RULE10 - peripheral marks reverse bytes as command or data with busy
// RULE11 - peripheral asserts ack on valid reverse data, interlocked with host ack
// RULE12 - forward host ack level tells command byte from data byte
// RULE13 - reverse host ack requests each byte and paces against ack
// RULE14 - peripheral drives paper error low to grant a reverse request
// RULE15 - data lines driven only while paper error shows forward direction
// RULE16 - fault low raises error interrupt, only meaningful in forward direction
// RULE17 - peripheral request is only a hint; software alone picks the direction
// RULE18 - init pin low selects reverse, high selects forward
// RULE19 - peripheral drives data only in link mode with host ack low
// RULE20 - select in pin held deasserted throughout link mode
// RULE21 - three bit mode field decoded into the eight documented modes; code builds no EPP, and modes 4 and 5 act as bidirectional mode 1
// RULE22 - low registers at 000h to 002h, upper at 400h to 402h
// RULE23 - link mode forward write at offset zero enters fifo tagged as address
// RULE24 - full and empty flags always follow true fifo occupancy
module ecpp_port import ecpp_pkg::*; (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [10:0] ioAddr,
  input wire logic ioWr,
  input wire logic ioRd,
  input wire logic [7:0] ioWrData,
  output logic [7:0] ioRdData,
  input wire logic dmaAck,
  output logic dmaReq,
  output logic irqOut,
  input wire logic [7:0] pdIn,
  output logic [7:0] pdOut,
  output logic pdOe,
  output logic nStrobe,
  output logic nAutoFd,
  output logic nInit,
  output logic nSelectIn,
  input wire logic nAckIn,
  input wire logic busyIn,
  input wire logic pErrorIn,
  input wire logic selectIn,
  input wire logic nFaultIn
);
  logic [12:0] syncQ;
  logic [7:0] pdS;
  logic nAckS, busyS, pErrS, selS, nFaultS;
  logic fifoWrValid, fifoWrReady, fifoRdValid, fifoRdReady, fifoFlush;
  logic [FIFO_W-1:0] fifoWrData, fifoRdData;
  logic [4:0] fifoCount;
  // register group
  logic [7:0] dataReg_ff, nxt_dataReg, rdData_ff, nxt_rdData, lastRd_ff, nxt_lastRd;
  logic [5:0] ctrl_ff, nxt_ctrl;
  logic [2:0] mode_ff, nxt_mode;
  logic nErrIe_ff, nxt_nErrIe, dma_enable_bit_ff, nxt_dma_enable_bit, svc_ff, nxt_svc;
  logic irq_ff, nxt_irq, nAckPrev_ff, nxt_nAckPrev;
  // link group
  ecpp_link_e state_ff, nxt_state;
  logic [7:0] outByte_ff, nxt_outByte, revByte_ff, nxt_revByte, timer_ff, nxt_timer, pend_ff, nxt_pend;
  logic [6:0] rleCnt_ff, nxt_rleCnt;
  logic outTag_ff, nxt_outTag, revTag_ff, nxt_revTag, rleArmed_ff, nxt_rleArmed;
  // pin group
  logic [7:0] pdOut_ff, nxt_pdOut;
  logic pdOe_ff, nxt_pdOe, nStrobe_ff, nxt_nStrobe, nAutoFd_ff, nxt_nAutoFd;
  logic nInit_ff, nxt_nInit, nSelectIn_ff, nxt_nSelectIn;
  logic fifoMode, dirEff, fwdOk, revOk, hostFifo, addrFifo, hostPush, hostPop, linkPush, linkPop, hwSvc;

  ecpp_sync #(.W(13), .RST_VAL(SYNC_RST)) u_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .ce(ce),
    .d({nAckIn, busyIn, pErrorIn, selectIn, nFaultIn, pdIn}),
    .q(syncQ)
  );
  assign {nAckS, busyS, pErrS, selS, nFaultS, pdS} = syncQ;

  // shared fifo, tag bit marks address bytes in both directions; run length bytes are never stored
  ecpp_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_DEPTH)) u_fifo ( // see RULE2
    .sys_clk(sys_clk),
    .rst(rst),
    .ce(ce),
    .flush(fifoFlush),
    .wrValid(fifoWrValid),
    .wrReady(fifoWrReady),
    .wrData(fifoWrData),
    .rdValid(fifoRdValid),
    .rdReady(fifoRdReady),
    .rdData(fifoRdData),
    .count(fifoCount)
  );

  // mode qualifiers
  assign fifoMode = (mode_ff == MODE_COMPAT_DATA_FIFO) || (mode_ff == MODE_ECP) || (mode_ff == MODE_TEST); // see RULE21
  assign dirEff = ctrl_ff[CTRL_DIR] && (mode_ff != MODE_STD) && (mode_ff != MODE_COMPAT_DATA_FIFO);
  assign fwdOk = (mode_ff == MODE_COMPAT_DATA_FIFO) || ((mode_ff == MODE_ECP) && !dirEff && pErrS); // see RULE14
  // direction follows software only, fault pin never turns it
  assign revOk = (mode_ff == MODE_ECP) && dirEff && !pErrS; // see RULE17
  assign hostFifo = (ioAddr == OFF_FIFO) && fifoMode; // see RULE22
  assign addrFifo = (ioAddr == OFF_DATA) && (mode_ff == MODE_ECP) && !dirEff; // see RULE23
  assign hostPush = ((ioWr && (hostFifo || addrFifo)) || (dmaAck && fifoMode && !dirEff)) && !linkPush; // see RULE4
  assign hostPop = ((ioRd && hostFifo) || (dmaAck && fifoMode && dirEff)) && !linkPop;
  assign fifoWrValid = linkPush || hostPush;
  assign fifoWrData = linkPush ? {revTag_ff, revByte_ff} : {addrFifo && !dmaAck, ioWrData}; // see RULE1
  assign fifoRdReady = linkPop || hostPop;
  assign fifoFlush = ioWr && (ioAddr == OFF_ECR) && (ioWrData[7:5] != mode_ff);
  assign hwSvc = !dma_enable_bit_ff && ((mode_ff == MODE_COMPAT_DATA_FIFO) || (mode_ff == MODE_ECP)) &&
                 (dirEff ? (fifoCount >= 5'(SVC_THRESH)) : (fifoCount <= 5'(FIFO_DEPTH - SVC_THRESH)));
  assign dmaReq = dma_enable_bit_ff && fifoMode && (dirEff ? fifoRdValid : fifoWrReady); // see RULE4

  // register file
  always_comb begin
    nxt_dataReg = dataReg_ff;
    nxt_ctrl = ctrl_ff;
    nxt_mode = mode_ff;
    nxt_nErrIe = nErrIe_ff;
    nxt_dma_enable_bit = dma_enable_bit_ff;
    nxt_svc = svc_ff;
    nxt_rdData = rdData_ff;
    nxt_lastRd = lastRd_ff;
    nxt_nAckPrev = nAckS;
    nxt_irq = (!nErrIe_ff && !nFaultS && !dirEff) || (ctrl_ff[CTRL_ACKIE] && nAckS && !nAckPrev_ff); // see RULE16
    if (hostPop && fifoRdValid) nxt_lastRd = fifoRdData[7:0];
    if (ioWr) begin
      unique case (ioAddr)
        OFF_DATA: if (!addrFifo) nxt_dataReg = ioWrData; // see RULE3
        OFF_CTRL: nxt_ctrl = ioWrData[5:0];
        OFF_ECR: begin
          nxt_mode = ioWrData[7:5]; // see RULE21
          nxt_nErrIe = ioWrData[ECR_NERRIE];
          nxt_dma_enable_bit = ioWrData[ECR_DMA_ENABLE_BIT];
          nxt_svc = ioWrData[ECR_SVC];
        end
        default: ;
      endcase
    end
    if (hwSvc) nxt_svc = 1'b1;
    if (ioRd) begin
      unique case (ioAddr)
        OFF_DATA: nxt_rdData = pdS;
        OFF_STAT: nxt_rdData = {!busyS, nAckS, pErrS, selS, nFaultS, 3'h0};
        OFF_CTRL: nxt_rdData = {2'h0, ctrl_ff};
        OFF_FIFO: begin
          if (mode_ff == MODE_CFG) nxt_rdData = CONFIG_A_VAL;
          else if (hostFifo && fifoRdValid) nxt_rdData = fifoRdData[7:0];
          else nxt_rdData = lastRd_ff;
        end
        // compression bit reads zero: forward bytes leave uncompressed
        OFF_CFGB: nxt_rdData = (mode_ff == MODE_CFG) ? {1'b0, irq_ff, 6'h00} : 8'h00; // see RULE7
        OFF_ECR: nxt_rdData = {mode_ff, nErrIe_ff, dma_enable_bit_ff, svc_ff, !fifoWrReady, !fifoRdValid}; // see RULE24
        default: nxt_rdData = 8'h00;
      endcase
    end else if (hostPop && fifoRdValid) begin
      nxt_rdData = fifoRdData[7:0];
    end
  end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      dataReg_ff <= 8'h00;
      ctrl_ff <= CTRL_RST;
      mode_ff <= MODE_RST;
      nErrIe_ff <= 1'b0;
      dma_enable_bit_ff <= 1'b0;
      svc_ff <= 1'b0;
      rdData_ff <= 8'h00;
      lastRd_ff <= 8'h00;
      irq_ff <= 1'b0;
      nAckPrev_ff <= 1'b1;
    end else if (ce) begin
      dataReg_ff <= nxt_dataReg;
      ctrl_ff <= nxt_ctrl;
      mode_ff <= nxt_mode;
      nErrIe_ff <= nxt_nErrIe;
      dma_enable_bit_ff <= nxt_dma_enable_bit;
      svc_ff <= nxt_svc;
      rdData_ff <= nxt_rdData;
      lastRd_ff <= nxt_lastRd;
      irq_ff <= nxt_irq;
      nAckPrev_ff <= nxt_nAckPrev;
    end
  end

  // link handshake engine
  always_comb begin
    nxt_state = state_ff;
    nxt_outByte = outByte_ff;
    nxt_outTag = outTag_ff;
    nxt_timer = timer_ff;
    nxt_revByte = revByte_ff;
    nxt_revTag = revTag_ff;
    nxt_rleCnt = rleCnt_ff;
    nxt_rleArmed = rleArmed_ff;
    nxt_pend = pend_ff;
    linkPop = 1'b0;
    linkPush = 1'b0;
    unique case (state_ff)
      LK_IDLE: begin
        if (fwdOk && fifoRdValid && !busyS) begin // see RULE9
          linkPop = 1'b1;
          nxt_outByte = fifoRdData[7:0];
          nxt_outTag = fifoRdData[8];
          nxt_state = LK_SETUP;
        end else if (revOk) begin
          nxt_state = LK_REV_REQ;
        end
      end
      LK_SETUP: begin
        nxt_timer = 8'(STROBE_CYC - 1);
        nxt_state = LK_STROBE; // see RULE8
      end
      LK_STROBE: begin
        if (mode_ff == MODE_COMPAT_DATA_FIFO) begin
          if (timer_ff == 8'h00) nxt_state = LK_RELEASE; // see RULE5
          else nxt_timer = timer_ff - 8'h01;
        end else if (busyS || mode_ff != MODE_ECP) begin
          nxt_state = LK_RELEASE; // see RULE8
        end
      end
      LK_RELEASE: if (!busyS) nxt_state = LK_IDLE; // see RULE5
      LK_REV_REQ: begin
        if (!revOk) begin
          nxt_state = LK_IDLE;
        end else if (!nAckS) begin // see RULE11
          nxt_revByte = pdS;
          nxt_revTag = !busyS; // see RULE10
          nxt_state = LK_REV_ACK;
          if (!busyS && !pdS[7]) begin
            nxt_rleCnt = pdS[6:0]; // see RULE6
            nxt_rleArmed = 1'b1;
            nxt_pend = 8'h00;
          end else if (!busyS) begin
            nxt_pend = 8'h01;
          end else begin
            nxt_pend = rleArmed_ff ? ({1'b0, rleCnt_ff} + 8'h01) : 8'h01; // see RULE6
            nxt_rleArmed = 1'b0;
          end
        end
      end
      LK_REV_ACK: begin
        if (pend_ff != 8'h00 && fifoWrReady) begin
          linkPush = 1'b1;
          nxt_pend = pend_ff - 8'h01;
        end
        if (pend_ff == 8'h00 && nAckS) nxt_state = LK_IDLE; // see RULE13
      end
    endcase
  end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_ff <= LK_IDLE;
      outByte_ff <= 8'h00;
      outTag_ff <= 1'b0;
      timer_ff <= 8'h00;
      revByte_ff <= 8'h00;
      revTag_ff <= 1'b0;
      rleCnt_ff <= 7'h00;
      rleArmed_ff <= 1'b0;
      pend_ff <= 8'h00;
    end else if (ce) begin
      state_ff <= nxt_state;
      outByte_ff <= nxt_outByte;
      outTag_ff <= nxt_outTag;
      timer_ff <= nxt_timer;
      revByte_ff <= nxt_revByte;
      revTag_ff <= nxt_revTag;
      rleCnt_ff <= nxt_rleCnt;
      rleArmed_ff <= nxt_rleArmed;
      pend_ff <= nxt_pend;
    end
  end

  // pin drivers
  always_comb begin
    nxt_nStrobe = !ctrl_ff[CTRL_STROBE]; // see RULE3
    nxt_nAutoFd = !ctrl_ff[CTRL_AUTOFD];
    nxt_nInit = ctrl_ff[CTRL_INIT];
    nxt_nSelectIn = !ctrl_ff[CTRL_SELIN];
    nxt_pdOut = dataReg_ff;
    nxt_pdOe = !dirEff;
    unique case (mode_ff)
      MODE_COMPAT_DATA_FIFO: begin
        nxt_nStrobe = state_ff != LK_STROBE; // see RULE5
        nxt_pdOut = outByte_ff;
      end
      MODE_ECP: begin
        nxt_nStrobe = state_ff != LK_STROBE; // see RULE8
        nxt_nAutoFd = dirEff ? (state_ff == LK_REV_ACK) : !outTag_ff; // see RULE12 see RULE13 see RULE19
        nxt_nInit = !dirEff; // see RULE18
        nxt_nSelectIn = 1'b1; // see RULE20
        nxt_pdOut = outByte_ff;
        nxt_pdOe = !dirEff && pErrS; // see RULE15
      end
      MODE_TEST: nxt_pdOut = fifoRdData[7:0];
      default: ;
    endcase
  end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pdOut_ff <= 8'h00;
      pdOe_ff <= 1'b1;
      nStrobe_ff <= 1'b1;
      nAutoFd_ff <= 1'b1;
      nInit_ff <= 1'b0;
      nSelectIn_ff <= 1'b1;
    end else if (ce) begin
      pdOut_ff <= nxt_pdOut;
      pdOe_ff <= nxt_pdOe;
      nStrobe_ff <= nxt_nStrobe;
      nAutoFd_ff <= nxt_nAutoFd;
      nInit_ff <= nxt_nInit;
      nSelectIn_ff <= nxt_nSelectIn;
    end
  end
  assign pdOut = pdOut_ff;
  assign pdOe = pdOe_ff;
  assign nStrobe = nStrobe_ff;
  assign nAutoFd = nAutoFd_ff;
  assign nInit = nInit_ff;
  assign nSelectIn = nSelectIn_ff;
  assign ioRdData = rdData_ff;
  assign irqOut = irq_ff;

  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst || !ce);
  sequence s_rle_cmd;
    state_ff == LK_REV_REQ && revOk && !nAckS && !busyS && !pdS[7];
  endsequence
  sequence s_rle_data;
    state_ff == LK_REV_REQ && revOk && !nAckS && busyS && rleArmed_ff;
  endsequence
  sequence s_compat_pulse;
    !nStrobe[*5] ##1 nStrobe;
  endsequence
  a_ecp_select_high: assert property (mode_ff == MODE_ECP |=> nSelectIn) // see RULE20
    else $error("select in asserted in link mode");
  a_dir_to_init: assert property (mode_ff == MODE_ECP && $stable(mode_ff) |=> nInit == !$past(dirEff)) // see RULE18
    else $error("init pin does not follow direction");
  a_drive_fwd_only: assert property (mode_ff == MODE_ECP && (dirEff || !pErrS) // see RULE15
    ##1 mode_ff == MODE_ECP |-> !pdOe)
    else $error("data lines driven without forward grant");
  a_strobe_release: assert property (state_ff == LK_STROBE && mode_ff == MODE_ECP && busyS // see RULE8
    |=> state_ff == LK_RELEASE ##1 nStrobe)
    else $error("strobe not released after busy");
  a_compat_pulse: assert property ($fell(nStrobe) && mode_ff == MODE_COMPAT_DATA_FIFO && $stable(mode_ff) // see RULE5
    |-> s_compat_pulse)
    else $error("compat strobe width wrong");
  a_rle_no_store: assert property (s_rle_cmd |=> pend_ff == 8'h00 && !linkPush) // see RULE6
    else $error("run length count byte stored");
  a_rle_repeat: assert property (s_rle_data |=> pend_ff == {1'b0, $past(rleCnt_ff)} + 8'h01) // see RULE6
    else $error("repeat count wrong");
  a_fifo_flags: assert property (ioRd && ioAddr == OFF_ECR // see RULE24
    |=> ioRdData[0] == ($past(fifoCount) == 5'h00) && ioRdData[1] == ($past(fifoCount) == 5'h10))
    else $error("fifo flags disagree with occupancy");
  a_err_irq: assert property (!nErrIe_ff && !nFaultS && !dirEff |=> irqOut) // see RULE16
    else $error("fault did not raise interrupt");
  a_host_ack: assert property (state_ff == LK_REV_REQ && mode_ff == MODE_ECP // see RULE13
    ##1 mode_ff == MODE_ECP |-> !nAutoFd)
    else $error("host ack not requesting");
endmodule // ecpp_port

// *** bench/ecpp_periph.sv ***
`timescale 1ns/1ns
module ecpp_periph (
  input wire logic sys_clk,
  input wire logic [7:0] pdOut,
  input wire logic pdOe,
  input wire logic nStrobe,
  input wire logic nAutoFd,
  input wire logic nInit,
  input wire logic nSelectIn,
  output logic [7:0] pdIn,
  output logic nAckIn,
  output logic busyIn,
  output logic pErrorIn,
  output logic selectIn,
  output logic nFaultIn
);
  logic [8:0] fwdQ[$];
  logic [8:0] revQ[$];
  int lag = 1;
  int lowCnt = 0;
  initial begin
    pdIn = 8'h00;
    nAckIn = 1'b1;
    busyIn = 1'b0;
    pErrorIn = 1'b1;
    selectIn = 1'b1;
    nFaultIn = 1'b1;
  end
  // strobe width meter
  always @(posedge sys_clk) begin
    if (nStrobe === 1'b0) lowCnt++;
  end
  // forward byte latched on strobe fall, busy interlock
  always @(negedge nStrobe) begin
    fwdQ.push_back({nAutoFd, pdOut});
    lowCnt = 0;
    repeat (lag) @(posedge sys_clk);
    #1 busyIn = 1'b1;
    while (nStrobe !== 1'b1) @(posedge sys_clk);
    repeat (lag) @(posedge sys_clk);
    #1 busyIn = 1'b0;
  end
  // direction grant follows init pin
  always @(posedge sys_clk) begin
    if (pErrorIn !== nInit) begin
      repeat (lag) @(posedge sys_clk);
      #1 pErrorIn = nInit;
    end
  end
  // reverse bytes, one per host ack request
  always @(posedge sys_clk) begin
    if (nInit === 1'b0 && pErrorIn === 1'b0 && nAutoFd === 1'b0 && nSelectIn === 1'b1 &&
        revQ.size() > 0) begin
      #1 {busyIn, pdIn} = revQ.pop_front();
      repeat (lag) @(posedge sys_clk);
      #1 nAckIn = 1'b0;
      while (nAutoFd !== 1'b1) @(posedge sys_clk);
      #1 nAckIn = 1'b1;
      pdIn = ~pdIn;
    end
  end
endmodule // ecpp_periph

// *** bench/tb_top.sv ***
`timescale 1ns/1ns
module tb_top;
  import ecpp_pkg::*;
  logic sys_clk, rst, ioWr, ioRd, dmaAck, dmaReq, irqOut, pdOe;
  logic nStrobe, nAutoFd, nInit, nSelectIn, nAckIn, busyIn, pErrorIn, selectIn, nFaultIn;
  logic [10:0] ioAddr;
  logic [7:0] ioWrData, ioRdData, pdIn, pdOut, d;
  int errorCnt = 0;
  int nChecks = 0;
  int cyc = 0;
  int irqCnt = 0;
  ecpp_port u_ecpp_port (.sys_clk(sys_clk), .rst(rst), .ce(1'b1), .ioAddr(ioAddr), .ioWr(ioWr), .ioRd(ioRd),
    .ioWrData(ioWrData), .ioRdData(ioRdData), .dmaAck(dmaAck), .dmaReq(dmaReq), .irqOut(irqOut), .pdIn(pdIn),
    .pdOut(pdOut), .pdOe(pdOe), .nStrobe(nStrobe), .nAutoFd(nAutoFd), .nInit(nInit), .nSelectIn(nSelectIn),
    .nAckIn(nAckIn), .busyIn(busyIn), .pErrorIn(pErrorIn), .selectIn(selectIn), .nFaultIn(nFaultIn));
  ecpp_periph u_ecpp_periph (.sys_clk(sys_clk), .pdOut(pdOut), .pdOe(pdOe), .nStrobe(nStrobe), .nAutoFd(nAutoFd),
    .nInit(nInit), .nSelectIn(nSelectIn), .pdIn(pdIn), .nAckIn(nAckIn), .busyIn(busyIn), .pErrorIn(pErrorIn),
    .selectIn(selectIn), .nFaultIn(nFaultIn));
  always #4 sys_clk = ~sys_clk;
  task automatic stop_test();
    $display("checks %0d mismatches %0d", nChecks, errorCnt);
    if (errorCnt == 0 && nChecks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc++;
    if (irqOut === 1'b1) irqCnt++;
    if (cyc == 20000) begin
      errorCnt++;
      stop_test();
    end
  end
  task automatic chk_byte(input string nm, input logic [8:0] e, input logic [8:0] g);
    nChecks++;
    if (g !== e) begin
      errorCnt++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic chk_bit(input string nm, input logic e, input logic g);
    nChecks++;
    if (g !== e) begin
      errorCnt++;
      $display("CHECK FAILED %s exp %b got %b", nm, e, g);
    end
  endtask
  task automatic wr(input logic [10:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    #1 ioAddr = a;
    ioWrData = v;
    ioWr = 1'b1;
    @(posedge sys_clk);
    #1 ioWr = 1'b0;
  endtask
  task automatic rd(input logic [10:0] a);
    @(posedge sys_clk);
    #1 ioAddr = a;
    ioRd = 1'b1;
    @(posedge sys_clk);
    #1 ioRd = 1'b0;
    d = ioRdData;
  endtask
  task automatic rdc(input logic [10:0] a, input logic [7:0] e);
    rd(a);
    chk_byte($sformatf("reg %h", a), {1'b0, e}, {1'b0, d});
  endtask
  task automatic wait_fwd(input int n);
    for (int i = 0; i < 400 && u_ecpp_periph.fwdQ.size() < n; i++) @(posedge sys_clk);
    #1;
  endtask
  task automatic test_reset();
    rdc(OFF_ECR, 8'h01);
    rdc(OFF_CTRL, 8'h00);
    chk_bit("nInit", 1'b0, nInit);
    chk_bit("nSelectIn", 1'b1, nSelectIn);
  endtask
  task automatic test_std();
    wr(OFF_DATA, 8'h3C);
    wr(OFF_CTRL, 8'h0F);
    repeat (2) @(posedge sys_clk);
    #1 chk_byte("pdOut", 9'h13C, {pdOe, pdOut});
    chk_byte("pins", 9'h002, {5'h0, nStrobe, nAutoFd, nInit, nSelectIn});
    wr(OFF_CTRL, 8'h04);
    repeat (12) @(posedge sys_clk);
    rdc(OFF_STAT, 8'hF8);
    rdc(11'h003, 8'h00);
    u_ecpp_periph.fwdQ.delete();
  endtask
  task automatic test_modes();
    for (int m = 0; m < 8; m++) begin
      wr(OFF_ECR, {m[2:0], 5'h00});
      rd(OFF_ECR);
      chk_byte("mode", {5'h0, m[2:0], 1'b1}, {5'h0, d[7:5], d[0]});
      if (m == 7) rdc(OFF_FIFO, CONFIG_A_VAL);
      if (m == 7) rdc(OFF_CFGB, 8'h00);
    end
  endtask
  task automatic test_test_fifo();
    wr(OFF_ECR, 8'hC0);
    for (int i = 0; i < 17; i++) wr(OFF_FIFO, 8'(i));
    rdc(OFF_ECR, 8'hC2);
    for (int i = 0; i < 16; i++) rdc(OFF_FIFO, 8'(i));
    rdc(OFF_FIFO, 8'h0F);
    rdc(OFF_ECR, 8'hC1);
  endtask
  task automatic test_compat();
    wr(OFF_ECR, 8'h40);
    wr(OFF_FIFO, 8'hA1);
    wr(OFF_FIFO, 8'hA2);
    wait_fwd(2);
    chk_byte("fwd0", 9'h0A1, {1'b0, u_ecpp_periph.fwdQ[0][7:0]});
    chk_byte("fwd1", 9'h0A2, {1'b0, u_ecpp_periph.fwdQ[1][7:0]});
    for (int i = 0; i < 50 && nStrobe !== 1'b1; i++) @(posedge sys_clk);
    chk_byte("strobe", 9'(STROBE_CYC), 9'(u_ecpp_periph.lowCnt));
    wr(OFF_ECR, 8'h48);
    repeat (2) @(posedge sys_clk);
    #1 chk_bit("dmaReq", 1'b1, dmaReq);
    ioWrData = 8'h77;
    dmaAck = 1'b1;
    @(posedge sys_clk);
    #1 dmaAck = 1'b0;
    wait_fwd(3);
    chk_byte("dma", 9'h077, {1'b0, u_ecpp_periph.fwdQ[2][7:0]});
    repeat (20) @(posedge sys_clk);
  endtask
  task automatic test_ecp_fwd();
    u_ecpp_periph.fwdQ.delete();
    wr(OFF_CTRL, 8'h0C);
    wr(OFF_ECR, 8'h60);
    repeat (2) @(posedge sys_clk);
    #1 chk_bit("nSelectIn", 1'b1, nSelectIn);
    wr(OFF_FIFO, 8'h11);
    wr(OFF_DATA, 8'h22);
    wait_fwd(2);
    chk_byte("data", 9'h111, u_ecpp_periph.fwdQ[0]);
    chk_byte("addr", 9'h022, u_ecpp_periph.fwdQ[1]);
    repeat (20) @(posedge sys_clk);
    #1 u_ecpp_periph.nFaultIn = 1'b0;
    repeat (6) @(posedge sys_clk);
    #1 chk_bit("irqOut", 1'b1, irqOut);
    chk_bit("nInit", 1'b1, nInit);
    u_ecpp_periph.nFaultIn = 1'b1;
    repeat (6) @(posedge sys_clk);
    #1 chk_bit("irqOut", 1'b0, irqOut);
  endtask
  task automatic test_ecp_rev();
    u_ecpp_periph.lag = 3;
    u_ecpp_periph.revQ = '{9'h003, 9'h1A5, 9'h15A};
    wr(OFF_CTRL, 8'h30);
    irqCnt = 0;
    repeat (2) @(posedge sys_clk);
    #1 chk_bit("nInit", 1'b0, nInit);
    for (int i = 0; i < 600 && u_ecpp_periph.revQ.size() > 0; i++) @(posedge sys_clk);
    repeat (30) @(posedge sys_clk);
    #1 chk_bit("pdOe", 1'b0, pdOe);
    for (int i = 0; i < 4; i++) rdc(OFF_FIFO, 8'hA5);
    rdc(OFF_FIFO, 8'h5A);
    rd(OFF_ECR);
    chk_bit("empty", 1'b1, d[0]);
    chk_byte("ackIrq", 9'h003, 9'(irqCnt));
  endtask
  initial begin
    sys_clk = 1'b0;
    rst = 1'b1;
    ioAddr = 11'h000;
    ioWr = 1'b0;
    ioRd = 1'b0;
    ioWrData = 8'h00;
    dmaAck = 1'b0;
    repeat (8) @(posedge sys_clk);
    #1 rst = 1'b0;
    test_reset();
    test_std();
    test_modes();
    test_test_fifo();
    test_compat();
    test_ecp_fwd();
    test_ecp_rev();
    stop_test();
  end
endmodule // tb_top
